// file: clocked_serial_auto_txrx_tb_top.sv
// Self-checking bench: APB register tasks and a peer on the serial lines.
// Assumes the checker binds itself to the design top.
`timescale 1ns/10ps
`define CHK(a, e) begin \
  n_checks++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, (a), (e)); \
  end \
end
module clocked_serial_auto_txrx_tb_top;
  logic clk, resetn, psel, penable, pwrite, lsb, rerr, sck_ext;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic pready, pslverr, sck_out, sck_oe_n, so_out, so_oe_n, si, si_use;
  logic [7:0] tx;
  int miscompares, n_checks, base;
  // Released clock line shows the outside clock, which idles high
  wire sck_line = sck_oe_n ? sck_ext : sck_out;
  logic [15:0] regs[4] = '{sca_pkg::IDX_MODE, sca_pkg::IDX_AUTO,
                           sca_pkg::IDX_IVL, sca_pkg::IDX_SHIFT};

  sca_top #(.DEPTH(16)) i_sca_top (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_in(sck_ext),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .so_out(so_out),
    .so_oe_n(so_oe_n), .si_in(si), .si_in_use(si_use)
  );
  sca_peer_model i_sca_peer_model (
    .sck(sck_line), .so(so_out), .released(sck_oe_n), .si(si),
    .lsb_first(lsb), .tx_byte(tx)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    complete_run();
  endtask

  // One APB transfer; read data and error land in rdat and rerr
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) give_up();
  endtask

  task automatic wait_frames(input int cnt);
    int k;
    k = 0;
    while (i_sca_peer_model.got.size() < cnt && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) give_up();
  endtask

  // Poll the busy bit until the block is done
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, sca_pkg::IDX_AUTO, 8'h00);
      k++;
    end while (rdat[3] !== 1'b0 && k < 200);
    if (k >= 200) give_up();
  endtask

  // Main sequence
  initial begin
    {resetn, psel, penable, pwrite, lsb} = 5'h00;
    sck_ext = 1'b1;
    {paddr, pwdata} = 64'h0;
    tx = 8'h3C;
    miscompares = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, regs[i], 8'h00);
      `CHK(rdat, 32'h0)
    end
    apb(1'b0, 16'hFF7D, 8'h00);
    `CHK({rerr, rdat}, 33'h100000000)
    apb(1'b1, sca_pkg::IDX_AUTO, 8'hFF);
    apb(1'b0, sca_pkg::IDX_AUTO, 8'h00);
    `CHK(rdat, 32'hC0)
    apb(1'b1, sca_pkg::IDX_AUTO, 8'h00);
    // Plain frames in both bit orders on every clock source
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 4; c++) begin
        lsb <= d[0];
        base = i_sca_peer_model.got.size();
        apb(1'b1, sca_pkg::IDX_MODE, {1'b1, d[0], 4'h0, c[1:0]});
        apb(1'b1, sca_pkg::IDX_SHIFT, 8'hA5);
        // External clock: the bench is clock master, 4 clk a phase
        for (int t = 0; t < 16 && c == 0; t++) begin
          repeat (4) @(posedge clk);
          sck_ext <= ~sck_ext;
        end
        wait_frames(base + 1);
        `CHK(i_sca_peer_model.got[base], 8'hA5)
        apb(1'b0, sca_pkg::IDX_SHIFT, 8'h00);
        `CHK(rdat, 32'h3C)
      end
    end
    // Disabled: clock held high, then handed back to the port
    apb(1'b1, sca_pkg::IDX_MODE, 8'h10);
    repeat (2) @(posedge clk);
    `CHK({sck_oe_n, sck_out}, 2'b01)
    `CHK({so_oe_n, si_use}, 2'b10)
    apb(1'b1, sca_pkg::IDX_MODE, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(sck_oe_n, 1'b1)
    // One-shot block of three bytes with reception
    for (int i = 0; i < 3; i++)
      apb(1'b1, sca_pkg::IDX_BUF + 16'(i), 8'h11 * 8'(i + 1));
    apb(1'b1, sca_pkg::IDX_PTR, 8'h02);
    apb(1'b1, sca_pkg::IDX_AUTO, 8'h80);
    lsb <= 1'b0;
    tx <= 8'h5A;
    base = i_sca_peer_model.got.size();
    apb(1'b1, sca_pkg::IDX_MODE, 8'hA1);
    apb(1'b1, sca_pkg::IDX_SHIFT, 8'h00);
    apb(1'b0, sca_pkg::IDX_AUTO, 8'h00);
    `CHK({rdat[3], si_use}, 2'b11)
    wait_idle();
    `CHK(i_sca_peer_model.got.size(), base + 3)
    for (int i = 0; i < 3; i++) begin
      `CHK(i_sca_peer_model.got[base + i], 8'h33 - 8'h11 * 8'(i))
      apb(1'b0, sca_pkg::IDX_BUF + 16'(i), 8'h00);
      `CHK(rdat, 32'h5A)
    end
    apb(1'b0, sca_pkg::IDX_PTR, 8'h00);
    `CHK(rdat, 32'h0)
    // Repeat block with reception off, then suspended
    apb(1'b1, sca_pkg::IDX_BUF, 8'h0F);
    apb(1'b1, sca_pkg::IDX_AUTO, 8'h40);
    apb(1'b1, sca_pkg::IDX_PTR, 8'h01);
    tx <= 8'hC3;
    base = i_sca_peer_model.got.size();
    apb(1'b1, sca_pkg::IDX_SHIFT, 8'h00);
    wait_frames(base + 5);
    `CHK(si_use, 1'b0)
    `CHK(i_sca_peer_model.got[base + 2], 8'h5A)
    `CHK(i_sca_peer_model.got[base + 3], 8'h0F)
    apb(1'b0, sca_pkg::IDX_AUTO, 8'h00);
    `CHK(rdat[3], 1'b1)
    apb(1'b1, sca_pkg::IDX_MODE, 8'h00);
    apb(1'b0, sca_pkg::IDX_AUTO, 8'h00);
    `CHK(rdat[3], 1'b0)
    apb(1'b0, sca_pkg::IDX_BUF, 8'h00);
    `CHK(rdat, 32'h0F)
    complete_run();
  end
endmodule

// file: sca_peer_model.sv
// Peer device on the three serial lines: shifts a byte in and out.
// Assumes the clock line idles high and is pulled up when released.
`timescale 1ns/10ps
module sca_peer_model (
  // Serial lines
  input wire logic sck,
  input wire logic so,
  input wire logic released,
  output logic si,
  // Bench setup
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte
);
  int n = 0;
  logic armed = 1'b0;
  logic [7:0] rx = 8'h00;
  logic [7:0] got[$];

  // Drive the next bit after the falling clock
  initial si = 1'b0;
  always @(negedge sck) begin
    armed <= 1'b1;
    si <= lsb_first ? tx_byte[n] : tx_byte[7 - n];
  end

  // Sample on the rising clock, log each whole byte; the line settling
  // high at power-up is no clock edge, so wait for a first fall
  always @(posedge sck) if (armed) begin
    rx = lsb_first ? {so, rx[7:1]} : {rx[6:0], so};
    if (n == 7) begin
      got.push_back(rx);
      // Stale data only when the block owns the clock: it has sampled
      // already, while an outside clock is seen one clk late
      if (!released) si <= ~si;
      n = 0;
    end else begin
      n = n + 1;
    end
  end

  // A released clock pin ends any partial frame
  always @(posedge released) n = 0;
endmodule

// file: sca_pkg.sv
// Shared constants and types of the clocked serial block with auto
// transfer. Assumes a word-addressed APB slave: byte address = 4 * index.
package sca_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_MODE = 16'hFF78;
  localparam logic [15:0] IDX_AUTO = 16'hFF79;
  localparam logic [15:0] IDX_SHIFT = 16'hFF7A;
  localparam logic [15:0] IDX_IVL = 16'hFF7B;
  localparam logic [15:0] IDX_PTR = 16'hFF7C;
  localparam logic [15:0] IDX_BUF = 16'hFF80;

  // ----------------------------------------------------------------
  // Field positions, write masks and reset values
  // ----------------------------------------------------------------
  localparam int MODE_EN_B = 7;
  localparam int MODE_DIR_B = 6;
  localparam int MODE_AUTO_B = 5;
  localparam int MODE_IDLE_B = 4;
  localparam int AUTO_RE_B = 7;
  localparam int AUTO_RPT_B = 6;
  localparam int AUTO_TRF_B = 3;
  localparam int IVL_EN_B = 7;
  localparam logic [7:0] MODE_WMASK = 8'hF3;
  localparam logic [7:0] AUTO_WMASK = 8'hC0;
  localparam logic [7:0] IVL_WMASK = 8'h9F;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_AUTO = 8'h00;
  localparam logic [7:0] RST_IVL = 8'h00;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam logic [3:0] RST_PTR = 4'h0;

  // ----------------------------------------------------------------
  // Serial clock selection, half periods (in clk cycles), gap multiplier and last bit index
  // ----------------------------------------------------------------
  localparam logic [1:0] CKS_EXT = 2'h0;
  localparam logic [1:0] CKS_DIV4 = 2'h1;
  localparam logic [1:0] CKS_DIV8 = 2'h2;
  localparam logic [3:0] HALF_DIV4 = 4'h2;
  localparam logic [3:0] HALF_DIV8 = 4'h4;
  localparam logic [3:0] HALF_DIV16 = 4'h8;
  localparam logic [3:0] HALF_EXT = 4'h2;
  localparam logic [5:0] GAP_MULT_N0 = 6'h02;
  localparam logic [2:0] FRAME_LAST = 3'h7;

  // ----------------------------------------------------------------
  // Automatic transfer sequencer states, Gray along the loop except the LOAD to SHIFT step
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b11,
    ST_LOAD = 2'b10
  } sca_state_t;

endpackage

// file: sca_shift_if.sv
// Carrier between the control top and the shift engine.
// Assumes one clock domain; the edge strobes are one clk cycle long.
`timescale 1ns/10ps
interface sca_shift_if;
  logic enable;
  logic load;
  logic [7:0] load_data;
  logic lsb_first;
  logic rx_en;
  logic si;
  logic fall;
  logic rise;
  logic busy;
  logic done;
  logic so;
  logic [7:0] data;

  modport ctrl (
    output enable, load, load_data, lsb_first, rx_en, si, fall, rise,
    input busy, done, so, data
  );
  modport shifter (
    input enable, load, load_data, lsb_first, rx_en, si, fall, rise,
    output busy, done, so, data
  );
endinterface

// file: sca_shifter.sv
// Eight-bit serial shift engine with frame bit counter.
// Assumes fall/rise strobes from the control top, clock idling high.
`timescale 1ns/10ps
module sca_shifter (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control side
  sca_shift_if.shifter sif
);

  logic [7:0] sr_q;
  logic [2:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic so_q;
  logic rx_bit;
  logic [7:0] sr_shift;
  logic out_bit;

  // ----------------------------------------------------------------
  // Shift selection
  // ----------------------------------------------------------------
  // Receive bit is gated, so transmit-only work shifts in zeros
  assign rx_bit = sif.rx_en & sif.si;
  assign sr_shift = sif.lsb_first ? {rx_bit, sr_q[7:1]}
                                  : {sr_q[6:0], rx_bit};
  assign out_bit = sif.lsb_first ? sr_q[0] : sr_q[7];

  assign sif.busy = busy_q;
  assign sif.done = done_q;
  assign sif.so = so_q;
  assign sif.data = sr_q;

  // ----------------------------------------------------------------
  // Shift register and frame counter
  // ----------------------------------------------------------------
  // Load starts a frame only when enabled; disable clears the count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_q <= sca_pkg::RST_SHIFT;
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      so_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sif.load && !busy_q) begin
        sr_q <= sif.load_data;
        cnt_q <= 3'h0;
        busy_q <= sif.enable;
      end else if (!sif.enable) begin
        cnt_q <= 3'h0;
        busy_q <= 1'b0;
      end else if (busy_q && sif.fall) begin
        so_q <= out_bit;
      end else if (busy_q && sif.rise) begin
        sr_q <= sr_shift;
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == sca_pkg::FRAME_LAST) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

endmodule

// file: sca_top.sv
// Clocked three-wire serial interface with automatic block transfer,
// reached over APB. Assumes pin inputs synchronous to clk; pad logic
// outside combines the output-enable (active low) with port function.
//
// How it works
// - Eight-bit shift register converts parallel/serial, one bit per clock.
// - With interface enabled, writing the shift register starts a transfer.
// - Shift register data goes out serially; serial input shifts in.
// - Shift register clears to 00 on reset.
// - Byte pointer holds count minus one, decrements per byte.
// - Bit counter counts serial clocks to detect end of frame.
// - Interface disabled: no shifting, counter cleared, data pins released.
// - Bit-order bit: 0 sends MSB first, 1 sends LSB first.
// - Idle control drives clock pin high only while disabled.
// - Clock select: 00 external, else clk divided by 4, 8, 16.
// - Auto mode with receive disabled releases the data-in pin.
// - Receive-enable bit gates reception of the auto function.
// - Repeat bit: 0 one-shot, 1 repeat.
// - Busy status sets on shift write in auto mode, clears at end or suspend.
// - Mode, auto control and interval registers reset to 00.
// - Interval n gives 2 or n+1 serial periods plus half.
// - Auto function moves up to sixteen bytes unaided.
`timescale 1ns/10ps
module sca_top #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  // Serial data pins
  output logic so_out,
  output logic so_oe_n,
  input wire logic si_in,
  output logic si_in_use
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || DEPTH > 16) begin : g_bad_depth
    $error("DEPTH must lie between 2 and 16");
  end

  sca_shift_if sif ();

  logic [7:0] mode_q;
  logic re_q, rpt_q, trf_q;
  logic [7:0] ivl_q;
  logic [3:0] ptr_q, reload_q;
  logic [7:0] buf_q [DEPTH];
  sca_pkg::sca_state_t st_q, st_d;
  logic [3:0] div_q;
  logic sck_q, ext_q;
  logic [10:0] gap_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic sck_out_q, sck_oe_n_q, so_out_q, so_oe_n_q, si_use_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // True when an index falls in the transfer buffer window
  function automatic logic is_buf(input logic [15:0] idx);
    is_buf = (idx >= sca_pkg::IDX_BUF) &&
             (idx < sca_pkg::IDX_BUF + 16'(DEPTH));
  endfunction

  logic [15:0] idx;
  logic aligned, hit_mode, hit_auto, hit_shift, hit_ivl, hit_ptr, hit_buf;
  logic mapped, setup, wr_acc;
  logic wr_mode, wr_auto, wr_shift, wr_ivl, wr_ptr, wr_buf;
  logic [3:0] buf_sel;
  assign idx = paddr[17:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[31:18] == 14'h0);
  assign hit_mode = aligned && idx == sca_pkg::IDX_MODE;
  assign hit_auto = aligned && idx == sca_pkg::IDX_AUTO;
  assign hit_shift = aligned && idx == sca_pkg::IDX_SHIFT;
  assign hit_ivl = aligned && idx == sca_pkg::IDX_IVL;
  assign hit_ptr = aligned && idx == sca_pkg::IDX_PTR;
  assign hit_buf = aligned && is_buf(idx);
  assign buf_sel = 4'(idx - sca_pkg::IDX_BUF);
  assign mapped = hit_mode | hit_auto | hit_shift | hit_ivl | hit_ptr |
                  hit_buf;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready_q & pwrite & mapped;
  assign wr_mode = wr_acc & hit_mode;
  assign wr_auto = wr_acc & hit_auto;
  assign wr_shift = wr_acc & hit_shift;
  assign wr_ivl = wr_acc & hit_ivl;
  assign wr_ptr = wr_acc & hit_ptr;
  assign wr_buf = wr_acc & hit_buf;

  // ----------------------------------------------------------------
  // Mode fields
  // ----------------------------------------------------------------
  logic en, lsb, auto_md, idle_hi, int_clk;
  logic [1:0] cks;
  logic [3:0] half;
  assign en = mode_q[sca_pkg::MODE_EN_B];
  assign lsb = mode_q[sca_pkg::MODE_DIR_B];
  assign auto_md = mode_q[sca_pkg::MODE_AUTO_B];
  assign idle_hi = mode_q[sca_pkg::MODE_IDLE_B];
  assign cks = mode_q[1:0];
  assign int_clk = cks != sca_pkg::CKS_EXT;
  assign half = !int_clk ? sca_pkg::HALF_EXT :
                cks == sca_pkg::CKS_DIV4 ? sca_pkg::HALF_DIV4 :
                cks == sca_pkg::CKS_DIV8 ? sca_pkg::HALF_DIV8 :
                sca_pkg::HALF_DIV16;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  assign rd_byte = hit_mode ? mode_q :
    hit_auto ? {re_q, rpt_q, 2'h0, trf_q, 3'h0} :
    hit_shift ? sif.data :
    hit_ivl ? ivl_q :
    hit_ptr ? {4'h0, ptr_q} :
    hit_buf ? buf_q[buf_sel] : 8'h00;

  // ----------------------------------------------------------------
  // APB answer: ready in the access cycle, error for unmapped
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // Serial clock generation and edge strobes
  // ----------------------------------------------------------------
  // Divider runs only during a frame so the clock idles high
  logic tick, fall, rise;
  assign tick = div_q == half - 4'h1;
  assign fall = int_clk ? (tick & sck_q) : (ext_q & ~sck_in);
  assign rise = int_clk ? (tick & ~sck_q) : (~ext_q & sck_in);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 4'h0;
      sck_q <= 1'b1;
      ext_q <= 1'b1;
    end else begin
      ext_q <= sck_in;
      if (!sif.busy || !int_clk) begin
        div_q <= 4'h0;
        sck_q <= 1'b1;
      end else if (tick) begin
        div_q <= 4'h0;
        sck_q <= ~sck_q;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Automatic transfer sequencer
  // ----------------------------------------------------------------
  logic idle, auto_start, go, last, rx_ok;
  logic [5:0] mult;
  logic [10:0] gap_len;
  assign idle = st_q == sca_pkg::ST_IDLE;
  assign auto_start = wr_shift & en & auto_md & idle & ~sif.busy;
  assign go = auto_start | (st_q == sca_pkg::ST_LOAD);
  assign last = ptr_q == 4'h0;
  assign rx_ok = ~auto_md | re_q;
  assign mult = !ivl_q[sca_pkg::IVL_EN_B] ? 6'h00 :
                ivl_q[4:0] == 5'h00 ? sca_pkg::GAP_MULT_N0 :
                6'(ivl_q[4:0]) + 6'h01;
  assign gap_len = 11'({mult, 1'b1}) * 11'(half);

  // Next state; leaving enable suspends the block
  always_comb begin
    st_d = st_q;
    case (st_q)
      sca_pkg::ST_IDLE: if (auto_start) st_d = sca_pkg::ST_SHIFT;
      sca_pkg::ST_SHIFT:
        if (sif.done) begin
          st_d = (last && !rpt_q) ? sca_pkg::ST_IDLE
                                  : sca_pkg::ST_GAP;
        end
      sca_pkg::ST_GAP: if (gap_q >= gap_len) st_d = sca_pkg::ST_LOAD;
      sca_pkg::ST_LOAD: st_d = sca_pkg::ST_SHIFT;
      default: st_d = sca_pkg::ST_IDLE;
    endcase
    if (!en) st_d = sca_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= sca_pkg::ST_IDLE;
      gap_q <= 11'h000;
    end else begin
      st_q <= st_d;
      gap_q <= (st_q == sca_pkg::ST_GAP) ? gap_q + 11'h001 : 11'h000;
    end
  end

  // ----------------------------------------------------------------
  // Shift engine hookup
  // ----------------------------------------------------------------
  assign sif.enable = en;
  assign sif.load = (wr_shift & ~auto_md) | go;
  assign sif.load_data = auto_md ? buf_q[ptr_q] : pwdata[7:0];
  assign sif.lsb_first = lsb;
  assign sif.rx_en = rx_ok;
  assign sif.si = si_in;
  assign sif.fall = fall;
  assign sif.rise = rise;

  sca_shifter u_shifter (
    .clk(clk),
    .resetn(resetn),
    .sif(sif)
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic byte_done, trf_clr;
  assign byte_done = (st_q == sca_pkg::ST_SHIFT) & sif.done;
  assign trf_clr = ~en | (byte_done & last & ~rpt_q);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= sca_pkg::RST_MODE;
      re_q <= sca_pkg::RST_AUTO[sca_pkg::AUTO_RE_B];
      rpt_q <= sca_pkg::RST_AUTO[sca_pkg::AUTO_RPT_B];
      trf_q <= sca_pkg::RST_AUTO[sca_pkg::AUTO_TRF_B];
      ivl_q <= sca_pkg::RST_IVL;
    end else begin
      if (wr_mode) mode_q <= pwdata[7:0] & sca_pkg::MODE_WMASK;
      if (wr_auto) begin
        re_q <= pwdata[sca_pkg::AUTO_RE_B];
        rpt_q <= pwdata[sca_pkg::AUTO_RPT_B];
      end
      if (wr_ivl) ivl_q <= pwdata[7:0] & sca_pkg::IVL_WMASK;
      // Set wins over a clear in the same cycle
      if (auto_start) trf_q <= 1'b1;
      else if (trf_clr) trf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte pointer: counts down, reloads in repeat mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= sca_pkg::RST_PTR;
      reload_q <= sca_pkg::RST_PTR;
    end else begin
      if (auto_start) reload_q <= ptr_q;
      if (byte_done) begin
        ptr_q <= !last ? ptr_q - 4'h1 : (rpt_q ? reload_q : ptr_q);
      end else if (wr_ptr) begin
        ptr_q <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer buffer: received bytes replace sent ones
  // ----------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_buf
    logic hw_wr;
    assign hw_wr = byte_done & rx_ok & (ptr_q == 4'(i));
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        buf_q[i] <= 8'h00;
      end else if (hw_wr) begin
        buf_q[i] <= sif.data;
      end else if (wr_buf && buf_sel == 4'(i)) begin
        buf_q[i] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_out_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      so_out_q <= 1'b0;
      so_oe_n_q <= 1'b1;
      si_use_q <= 1'b0;
    end else begin
      sck_out_q <= en ? sck_q : 1'b1;
      sck_oe_n_q <= en ? ~int_clk : ~idle_hi;
      so_out_q <= sif.so;
      so_oe_n_q <= ~en;
      si_use_q <= en & rx_ok;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sck_out = sck_out_q;
  assign sck_oe_n = sck_oe_n_q;
  assign so_out = so_out_q;
  assign so_oe_n = so_oe_n_q;
  assign si_in_use = si_use_q;

endmodule

// file: sca_top_monitor.sv
// Checker for the serial block: watches the APB port and serial pins.
// Assumes word addressing of the package and the bind at the foot.
`timescale 1ns/10ps
module sca_top_monitor #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial pins
  input wire logic sck_in,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic so_out,
  input wire logic so_oe_n,
  input wire logic si_in_use
);
  // ----------------------------------------------------------------
  // Shadow of the control fields, clock fall counter
  // ----------------------------------------------------------------
  logic [7:0] mode_q;
  logic re_q;
  logic [3:0] falls_q;
  wire [15:0] idx = paddr[17:2];
  wire acc = psel && penable && pready;
  wire wr_ok = acc && pwrite && !pslverr;
  wire mode_wr = wr_ok && idx == sca_pkg::IDX_MODE;
  wire auto_wr = wr_ok && idx == sca_pkg::IDX_AUTO;
  wire shift_wr = wr_ok && idx == sca_pkg::IDX_SHIFT;
  wire in_regs = idx inside {[sca_pkg::IDX_MODE:sca_pkg::IDX_PTR]};
  wire in_buf = (idx - sca_pkg::IDX_BUF) < 16'(DEPTH);
  wire aligned = paddr[1:0] == 2'h0 && paddr[31:18] == 14'h0;
  wire mapped = aligned && (in_regs || in_buf);
  wire en = mode_q[sca_pkg::MODE_EN_B];
  wire idle = mode_q[sca_pkg::MODE_IDLE_B];
  wire auto_m = mode_q[sca_pkg::MODE_AUTO_B];
  wire [1:0] cks = mode_q[1:0];

  // Follow mode and receive-enable writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 8'h00;
      re_q <= 1'b0;
    end else begin
      if (mode_wr) mode_q <= pwdata[7:0] & sca_pkg::MODE_WMASK;
      if (auto_wr) re_q <= pwdata[sca_pkg::AUTO_RE_B];
    end
  end

  // Count clock falls since the last shift write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) falls_q <= 4'h0;
    else if (shift_wr) falls_q <= 4'h0;
    else if ($fell(sck_out) && falls_q != 4'hF) falls_q <= falls_q + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_err_unmapped: assert property (acc |-> pslverr == !mapped)
    else $error("slave error does not match the address map");
  a_off_released: assert property ((!en) [*2] |-> so_oe_n && !si_in_use)
    else $error("pins not released while disabled");
  a_idle_drive: assert property ((!en && idle) [*2] |->
      !sck_oe_n && sck_out)
    else $error("clock pin not held high while disabled");
  a_idle_port: assert property ((!en && !idle) [*2] |-> sck_oe_n)
    else $error("clock pin not released while disabled");
  a_rx_released: assert property ((en && auto_m && !re_q) [*2] |->
      !si_in_use)
    else $error("data-in pin kept with reception off");
  a_so_on_fall: assert property (!so_oe_n && $past(!so_oe_n) &&
      $changed(so_out) |-> !(cks == 2'h0 ? sck_in : sck_out))
    else $error("data out changed while clock high");
  a_div4_low: assert property (disable iff (!resetn || mode_wr)
      $fell(sck_out) && cks == 2'h1 |=> !sck_out ##1 sck_out)
    else $error("clock low phase not 2 cycles");
  a_div8_low: assert property (disable iff (!resetn || mode_wr)
      $fell(sck_out) && cks == 2'h2 |=> !sck_out [*3] ##1 sck_out)
    else $error("clock low phase not 4 cycles");
  a_div16_low: assert property (disable iff (!resetn || mode_wr)
      $fell(sck_out) && cks == 2'h3 |=> !sck_out [*7] ##1 sck_out)
    else $error("clock low phase not 8 cycles");
  a_frame_eight: assert property (shift_wr && en && !auto_m &&
      cks == 2'h1 |-> ##[2:60] (falls_q == 4'h8 && sck_out))
    else $error("plain frame did not give eight clocks");

  // Main scenarios reached
  c_auto_start: cover property (shift_wr && auto_m);
  c_full_frame: cover property (falls_q == 4'h8);
  c_refused: cover property (acc && pslverr);
endmodule

bind sca_top sca_top_monitor #(.DEPTH(DEPTH)) i_sca_top_monitor (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sck_in(sck_in), .sck_out(sck_out),
  .sck_oe_n(sck_oe_n),
  .so_out(so_out), .so_oe_n(so_oe_n), .si_in_use(si_in_use)
);
